// >>> timer_flags_and_prescaler.sv
// Timer event flags, shared prescaler and external clock path
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module timer_flags_and_prescaler
  import timer_flags_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [timer_flags_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [timer_flags_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [2:0] external_count_pin_i,
  input wire logic [3:0] t1_waveform_mode_field_i,
  input wire logic [3:0] t3_waveform_mode_field_i,
  input wire logic t1_capture_event_i,
  input wire logic t3_capture_event_i,
  input wire logic t1_at_top_i,
  input wire logic t3_at_top_i,
  input wire logic [2:0] t1_match_i,
  input wire logic [2:0] t3_match_i,
  input wire logic t1_overflow_i,
  input wire logic t3_overflow_i,
  input wire logic [7:0] vector_ack_i,
  input wire logic [7:0] ext_vector_ack_i,
  output logic [2:0] timer_tick_o,
  output logic [7:0] timer_event_flags_o,
  output logic [7:0] extended_timer_event_flags_o,
  output logic prescaler_held_o
);
  import timer_flags_pkg::*;

  logic aw_rdy_ff;
  logic w_rdy_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic ar_rdy_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_en;
  logic [7:0] flags_ff;
  logic [7:0] ext_flags_ff;
  logic [2:0] cs1_ff;
  logic [2:0] cs2_ff;
  logic [2:0] cs3_ff;
  logic psr_ff;
  logic sync_hold_ff;
  logic [9:0] prescale_ff;
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic [2:0] pin_s3_ff;
  logic [2:0] tick_ff;
  logic [2:0] nxt_tick;
  logic [7:0] flag_set;
  logic [7:0] ext_flag_set;
  logic [7:0] flag_clr;
  logic [7:0] ext_flag_clr;
  logic [31:0] ctrl_word;

  // Next flag value, a set takes priority over any clear
  function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                           input logic [7:0] set,
                                           input logic [7:0] clr);
    flag_next = set | (cur & ~clr);
  endfunction

  // Count enable chosen by a clock select code
  function automatic logic tick_select(input logic [2:0] cs,
                                       input logic [9:0] pre,
                                       input logic held,
                                       input logic rise,
                                       input logic fall);
    logic t;
    t = 1'b0;
    unique case (cs)
      CS_STOP: t = 1'b0;
      CS_DIRECT: t = 1'b1;
      CS_DIV8: t = ~held & (&pre[TAP8_W-1:0]);
      CS_DIV64: t = ~held & (&pre[TAP64_W-1:0]);
      CS_DIV256: t = ~held & (&pre[TAP256_W-1:0]);
      CS_DIV1024: t = ~held & (&pre[TAP1024_W-1:0]);
      CS_EXT_FALL: t = fall;
      CS_EXT_RISE: t = rise;
    endcase
    tick_select = t;
  endfunction

  // Capture register used as counter top
  function automatic logic cap_is_top(input logic [3:0] wm);
    cap_is_top = (wm == WM_CAP_TOP_A) || (wm == WM_CAP_TOP_B) ||
                 (wm == WM_CAP_TOP_C) || (wm == WM_CAP_TOP_D);
  endfunction

  assign wr_en = ~aw_rdy_ff & ~w_rdy_ff & ~bvalid_ff;

  assign ctrl_word = {sync_hold_ff, 14'h0000, psr_ff, 5'h00, cs3_ff,
                      1'b0, cs2_ff, 1'b0, cs1_ff};

  // Write address and data channels, taken in either order
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_rdy_ff <= 1'b1;
      w_rdy_ff <= 1'b1;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && aw_rdy_ff) begin
        aw_rdy_ff <= 1'b0;
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && w_rdy_ff) begin
        w_rdy_ff <= 1'b0;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      if (bvalid_ff && s_axi_bready_i) begin
        aw_rdy_ff <= 1'b1;
        w_rdy_ff <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_ff <= 1'b1;
      if (awaddr_ff == OFS_FLAGS || awaddr_ff == OFS_EXT_FLAGS ||
          awaddr_ff == OFS_CTRL) begin
        bresp_ff <= RESP_OKAY;
      end else begin
        bresp_ff <= RESP_DECERR;
      end
    end else if (bvalid_ff && s_axi_bready_i) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ar_rdy_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid_i && ar_rdy_ff) begin
      ar_rdy_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      unique case (s_axi_araddr_i)
        OFS_FLAGS: rdata_ff <= {24'h00_0000, flags_ff};
        OFS_EXT_FLAGS: rdata_ff <= {24'h00_0000, ext_flags_ff};
        OFS_CTRL: rdata_ff <= ctrl_word;
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= RESP_DECERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready_i) begin
      rvalid_ff <= 1'b0;
      ar_rdy_ff <= 1'b1;
    end
  end

  // Clock selects per timer
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs1_ff <= CS_RST;
      cs2_ff <= CS_RST;
      cs3_ff <= CS_RST;
    end else if (wr_en && awaddr_ff == OFS_CTRL) begin
      if (wstrb_ff[0]) begin
        cs1_ff <= wdata_ff[CS1_LSB +: 3];
        cs2_ff <= wdata_ff[CS2_LSB +: 3];
      end
      if (wstrb_ff[1]) begin
        cs3_ff <= wdata_ff[CS3_LSB +: 3];
      end
    end
  end

  // Prescaler reset and synchronization hold
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      psr_ff <= 1'b0;
      sync_hold_ff <= 1'b0;
    end else if (wr_en && awaddr_ff == OFS_CTRL &&
                 (wstrb_ff[2] || wstrb_ff[3])) begin
      if (wstrb_ff[3]) begin
        sync_hold_ff <= wdata_ff[SYNC_BIT];
      end
      if (wstrb_ff[3] && !wdata_ff[SYNC_BIT] && sync_hold_ff) begin
        psr_ff <= 1'b0;
      end else if (wstrb_ff[2]) begin
        psr_ff <= wdata_ff[PSR_BIT];
      end
    end else if (!sync_hold_ff) begin
      psr_ff <= 1'b0;
    end
  end

  // Free-running prescaler shared by timers 1, 2 and 3
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prescale_ff <= PRESCALE_RST;
    end else if (psr_ff) begin
      prescale_ff <= PRESCALE_RST;
    end else begin
      prescale_ff <= prescale_ff + 10'h001;
    end
  end

  // External count pins: two sampling stages, then edge history
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
      pin_s3_ff <= 3'h0;
    end else begin
      pin_s1_ff <= external_count_pin_i;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // Tick per timer; external edges bypass the prescaler
  always_comb begin
    nxt_tick[0] = tick_select(cs1_ff, prescale_ff, psr_ff,
                              pin_s2_ff[0] & ~pin_s3_ff[0],
                              ~pin_s2_ff[0] & pin_s3_ff[0]);
    nxt_tick[1] = tick_select(cs2_ff, prescale_ff, psr_ff,
                              pin_s2_ff[1] & ~pin_s3_ff[1],
                              ~pin_s2_ff[1] & pin_s3_ff[1]);
    nxt_tick[2] = tick_select(cs3_ff, prescale_ff, psr_ff,
                              pin_s2_ff[2] & ~pin_s3_ff[2],
                              ~pin_s2_ff[2] & pin_s3_ff[2]);
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_ff <= 3'h0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  // Flag set conditions; only true equality sets a match flag
  always_comb begin
    flag_set = 8'h00;
    ext_flag_set = 8'h00;
    flag_set[BIT_T1_CAPTURE] = cap_is_top(t1_waveform_mode_field_i) ?
      (tick_ff[0] & t1_at_top_i) : t1_capture_event_i;
    flag_set[BIT_T1_MATCH_A] = tick_ff[0] & t1_match_i[0];
    flag_set[BIT_T1_MATCH_B] = tick_ff[0] & t1_match_i[1];
    flag_set[BIT_T1_OVERFLOW] = tick_ff[0] & t1_overflow_i;
    ext_flag_set[BIT_T3_CAPTURE] = cap_is_top(t3_waveform_mode_field_i) ?
      (tick_ff[2] & t3_at_top_i) : t3_capture_event_i;
    ext_flag_set[BIT_T3_MATCH_A] = tick_ff[2] & t3_match_i[0];
    ext_flag_set[BIT_T3_MATCH_B] = tick_ff[2] & t3_match_i[1];
    ext_flag_set[BIT_T3_MATCH_C] = tick_ff[2] & t3_match_i[2];
    ext_flag_set[BIT_T3_OVERFLOW] = tick_ff[2] & t3_overflow_i;
    ext_flag_set[BIT_T1_MATCH_C] = tick_ff[0] & t1_match_i[2];
  end

  // Clear by vector execution or by writing one
  always_comb begin
    flag_clr = vector_ack_i;
    ext_flag_clr = ext_vector_ack_i;
    if (wr_en && awaddr_ff == OFS_FLAGS && wstrb_ff[0]) begin
      flag_clr = flag_clr | wdata_ff[7:0];
    end
    if (wr_en && awaddr_ff == OFS_EXT_FLAGS && wstrb_ff[0]) begin
      ext_flag_clr = ext_flag_clr | wdata_ff[7:0];
    end
  end

  // Flag registers; unused positions stay zero
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_ff <= FLAGS_RST;
      ext_flags_ff <= FLAGS_RST;
    end else begin
      flags_ff <= flag_next(flags_ff, flag_set, flag_clr) &
                  8'h3C;
      ext_flags_ff <= flag_next(ext_flags_ff, ext_flag_set,
                                ext_flag_clr) & 8'h3F;
    end
  end

  assign s_axi_awready_o = aw_rdy_ff;
  assign s_axi_wready_o = w_rdy_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = ar_rdy_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign timer_tick_o = tick_ff;
  assign timer_event_flags_o = flags_ff;
  assign extended_timer_event_flags_o = ext_flags_ff;
  assign prescaler_held_o = psr_ff;
endmodule
`default_nettype wire

// >>> timer_flags_pkg.sv
// Constants for timer event flags, prescaler and register map
package timer_flags_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_EXT_FLAGS = 4'h4;
  localparam logic [3:0] OFS_CTRL = 4'h8;
  localparam int ADDR_W = 4;
  // Event flag register bit positions
  localparam int BIT_T1_CAPTURE = 5;
  localparam int BIT_T1_MATCH_A = 4;
  localparam int BIT_T1_MATCH_B = 3;
  localparam int BIT_T1_OVERFLOW = 2;
  // Extended event flag register bit positions
  localparam int BIT_T3_CAPTURE = 5;
  localparam int BIT_T3_MATCH_A = 4;
  localparam int BIT_T3_MATCH_B = 3;
  localparam int BIT_T3_OVERFLOW = 2;
  localparam int BIT_T3_MATCH_C = 1;
  localparam int BIT_T1_MATCH_C = 0;
  // Control register fields
  localparam int CS1_LSB = 0;
  localparam int CS2_LSB = 4;
  localparam int CS3_LSB = 8;
  localparam int PSR_BIT = 16;
  localparam int SYNC_BIT = 31;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [2:0] CS_RST = 3'h0;
  localparam logic [9:0] PRESCALE_RST = 10'h000;
  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // Prescaler tap widths (log2 of divisor)
  localparam int TAP8_W = 3;
  localparam int TAP64_W = 6;
  localparam int TAP256_W = 8;
  localparam int TAP1024_W = 10;
  // Waveform modes that use the capture register as top
  localparam logic [3:0] WM_CAP_TOP_A = 4'h8;
  localparam logic [3:0] WM_CAP_TOP_B = 4'hA;
  localparam logic [3:0] WM_CAP_TOP_C = 4'hC;
  localparam logic [3:0] WM_CAP_TOP_D = 4'hE;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// >>> timer_flags_checker.sv
// Concurrent checks on timer flags and bus handshakes
`timescale 1ns/100ps
`default_nettype none
module timer_flags_checker (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic t1_capture_event_i,
  input wire logic [3:0] t1_waveform_mode_field_i,
  input wire logic t1_at_top_i,
  input wire logic [2:0] t1_match_i,
  input wire logic t1_overflow_i,
  input wire logic [7:0] vector_ack_i,
  input wire logic [2:0] timer_tick_o,
  input wire logic [7:0] timer_event_flags_o
);
  logic cap_top;
  logic tk1;
  logic hit_a;
  logic [7:0] fl;
  assign cap_top = t1_waveform_mode_field_i[3] &
    ~t1_waveform_mode_field_i[0];
  assign tk1 = timer_tick_o[0];
  assign hit_a = tk1 & t1_match_i[0];
  assign fl = timer_event_flags_o;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  chk_cap_pin: assert property (
    t1_capture_event_i && !cap_top |=> fl[5]) else $error("capture lost");
  chk_cap_top: assert property (
    tk1 && t1_at_top_i && cap_top |=> fl[5]) else $error("top lost");
  chk_match_b: assert property (
    tk1 && t1_match_i[1] |=> fl[3]) else $error("match b lost");
  chk_ovf_set: assert property (
    tk1 && t1_overflow_i |=> fl[2]) else $error("overflow lost");
  chk_match_cause: assert property (
    $rose(fl[4]) |-> $past(hit_a)) else $error("match a uncaused");
  chk_ack_clear: assert property (
    vector_ack_i[4] && !hit_a |=> !fl[4]) else $error("ack ignored");
  chk_flag_keep: assert property (
    fl[5] && !vector_ack_i[5] && s_axi_awready_o |=> fl[5])
    else $error("capture flag dropped");
  chk_aw_block: assert property (
    s_axi_bvalid_o |-> !s_axi_awready_o) else $error("aw open early");
  chk_ar_block: assert property (
    s_axi_rvalid_o |-> !s_axi_arready_o) else $error("ar open early");
endmodule
bind timer_flags_and_prescaler timer_flags_checker chk_u (.*);
`default_nettype wire

// >>> count_pin_model.sv
// External count pin source, idles low outside bursts
`timescale 1ns/100ps
`default_nettype none
module count_pin_model (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  output logic pin_o
);
  logic [1:0] cnt_ff;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= 2'h0;
      pin_o <= 1'b0;
    end else if (!run_i) begin
      cnt_ff <= 2'h0; // Pin steady around enable changes
      pin_o <= 1'b0;
    end else if (cnt_ff == 2'h2) begin
      cnt_ff <= 2'h0; // Half period of three clocks
      pin_o <= ~pin_o;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
// Testbench for timer flags, prescaler and clock select
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import timer_flags_pkg::*;
  logic clk_sys_i, arst_n_i, awv, wv, bre, arv, rre, run, pin;
  logic awrdy, wrdy, bv, arrdy, rv, held, c1, c3, top1, top3, o1, o3;
  logic [ADDR_W-1:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] br, rr;
  logic [2:0] tk, m1, m3;
  logic [3:0] wm1;
  logic [7:0] va, eva, fl, efl;
  int error_cnt, num_checks;
  int tc [3];
  logic [11:0] pv [6] = '{12'h800, 12'h400, 12'h038, 12'h007, 12'h0C0,
    12'h300};
  logic [7:0] ef [6] = '{8'h20, 8'h00, 8'h18, 8'h00, 8'h04, 8'h20};
  logic [7:0] ee [6] = '{8'h00, 8'h20, 8'h01, 8'h1A, 8'h04, 8'h20};
  int et [6] = '{0, 2048, 256, 32, 8, 2};
  timer_flags_and_prescaler dut_u (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rre), .external_count_pin_i({3{pin}}),
    .t1_waveform_mode_field_i(wm1), .t3_waveform_mode_field_i(wm1),
    .t1_capture_event_i(c1), .t3_capture_event_i(c3), .t1_at_top_i(top1),
    .t3_at_top_i(top3), .t1_match_i(m1), .t3_match_i(m3),
    .t1_overflow_i(o1), .t3_overflow_i(o3), .vector_ack_i(va),
    .ext_vector_ack_i(eva), .timer_tick_o(tk), .timer_event_flags_o(fl),
    .extended_timer_event_flags_o(efl), .prescaler_held_o(held)
  );
  count_pin_model pin_u (.clk_i(clk_sys_i), .arst_n_i(arst_n_i),
    .run_i(run), .pin_o(pin));
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!bv && n < 100);
    bre <= 1'b0;
    if (n >= 100) error_cnt++;
    if (n >= 100) summarize();
    chk({30'h0, br}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] e,
      input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (arv && arrdy) arv <= 1'b0;
    end while (!rv && n < 100);
    rre <= 1'b0;
    if (n >= 100) error_cnt++;
    if (n >= 100) summarize();
    chk(rdat, e);
    chk({30'h0, rr}, {30'h0, er});
  endtask
  task automatic pulse(input logic [11:0] v);
    @(posedge clk_sys_i);
    {c1, c3, top1, top3, o1, o3, m1, m3} <= v;
    @(posedge clk_sys_i);
    {c1, c3, top1, top3, o1, o3, m1, m3} <= 12'h000;
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic count(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      for (int i = 0; i < 3; i++) tc[i] += int'(tk[i]);
    end
  endtask
  initial begin
    {awv, wv, bre, arv, rre, run, c1, c3, top1, top3, o1, o3} = '0;
    {awa, ara, wd, m1, m3, wm1, va, eva} = '0;
    {error_cnt, num_checks, arst_n_i} = '0;
    repeat (8) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    axi_rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    axi_rd(OFS_EXT_FLAGS, 32'h0, RESP_OKAY);
    axi_rd(4'hC, 32'h0, RESP_DECERR);
    axi_wr(4'hC, 32'h0000_0001, RESP_DECERR);
    axi_rd(OFS_CTRL, 32'h0, RESP_OKAY);
    $display("test map done");
    for (int i = 0; i < 6; i++) begin
      axi_wr(OFS_CTRL, 32'h0000_0150 | 32'(i), RESP_OKAY);
      repeat (4) @(posedge clk_sys_i);
      tc = '{0, 0, 0};
      count(2048);
      chk(tc[0], et[i]);
      chk(tc[1], 2);
      chk(tc[2], 2048);
    end
    $display("test taps done");
    axi_wr(OFS_CTRL, 32'h8001_0432, RESP_OKAY);
    repeat (2) @(posedge clk_sys_i);
    tc = '{0, 0, 0};
    count(300);
    chk({31'h0, held}, 1);
    chk(tc[0] + tc[1] + tc[2], 0);
    axi_wr(OFS_CTRL, 32'h0000_0432, RESP_OKAY);
    tc = '{0, 0, 0};
    count(12);
    chk(tc[0], 1);
    chk({31'h0, held}, 0);
    axi_wr(OFS_CTRL, 32'h0001_0432, RESP_OKAY);
    chk({31'h0, held}, 1);
    tc = '{0, 0, 0};
    count(8);
    chk(tc[0], 0);
    count(1);
    chk(tc[0], 1);
    chk({31'h0, held}, 0);
    $display("test prescaler reset done");
    for (int j = 7; j > 5; j--) begin
      axi_wr(OFS_CTRL, 32'h0000_0111 * j, RESP_OKAY);
      tc = '{0, 0, 0};
      run <= 1'b1;
      count(24);
      run <= 1'b0;
      count(6);
      for (int i = 0; i < 3; i++) chk(tc[i], 4);
    end
    $display("test external clock done");
    axi_wr(OFS_CTRL, 32'h0000_0101, RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      wm1 <= (i == 5) ? 4'h8 : 4'h0;
      pulse(pv[i]);
      chk({24'h0, fl}, 32'(ef[i]));
      chk({24'h0, efl}, 32'(ee[i]));
      axi_rd(OFS_FLAGS, 32'(ef[i]), RESP_OKAY);
      axi_rd(OFS_EXT_FLAGS, 32'(ee[i]), RESP_OKAY);
      axi_wr(OFS_FLAGS, 32'h0, RESP_OKAY);
      axi_rd(OFS_FLAGS, 32'(ef[i]), RESP_OKAY);
      axi_wr(OFS_FLAGS, 32'h3C, RESP_OKAY);
      axi_wr(OFS_EXT_FLAGS, 32'h3F, RESP_OKAY);
      axi_rd(OFS_FLAGS, 32'h0, RESP_OKAY);
      axi_rd(OFS_EXT_FLAGS, 32'h0, RESP_OKAY);
    end
    $display("test flags done");
    pulse(12'h009);
    axi_rd(OFS_FLAGS, 32'h10, RESP_OKAY);
    @(posedge clk_sys_i);
    va <= 8'h10;
    eva <= 8'h10;
    @(posedge clk_sys_i);
    va <= 8'h00;
    eva <= 8'h00;
    axi_rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    axi_rd(OFS_EXT_FLAGS, 32'h0, RESP_OKAY);
    fork
      axi_wr(OFS_FLAGS, 32'h10, RESP_OKAY);
      begin
        repeat (2) @(posedge clk_sys_i);
        m1 <= 3'h1;
        @(posedge clk_sys_i);
        m1 <= 3'h0;
      end
    join
    axi_rd(OFS_FLAGS, 32'h10, RESP_OKAY);
    $display("test ack and priority done");
    summarize();
  end
endmodule
`default_nettype wire
